// *** psp_pkg.sv ***
// constants and types for the pipelined sram port
package psp_pkg;
	localparam int LANES  = 4;
	localparam int BYTE_W = 8;
	localparam int DATA_W = LANES * BYTE_W;
	localparam int ADDR_W = 6;
	localparam int DEPTH  = 64;
	localparam int LOW_W  = 2;
	localparam int HIGH_W = ADDR_W - LOW_W;
	localparam int IR_W   = 2;

	typedef logic [ADDR_W-1:0] psp_addr_t;
	typedef logic [LOW_W-1:0]  psp_low_t;
	typedef logic [HIGH_W-1:0] psp_high_t;
	typedef logic [IR_W-1:0]   psp_ir_t;

	localparam psp_low_t BURST_START = 2'h0;
	localparam psp_low_t BURST_STEP  = 2'h1;
	localparam logic     STRAP_DEFAULT = 1'h1;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	localparam psp_ir_t  IR_CAPTURE = 2'h1;
	localparam psp_ir_t  IR_BYPASS  = 2'h3;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
	} psp_tap_e;
endpackage : psp_pkg

// *** psp_if.sv ***
// carriers between the port core and its burst and test-port helpers
`timescale 1ns/1ps
interface psp_burst_if;
	logic              step;
	logic              load;
	psp_pkg::psp_low_t loadLow;
	logic              order;
	psp_pkg::psp_low_t curLow;
	modport ctl  (output step, output load, output loadLow, output order, input curLow);
	modport core (input step, input load, input loadLow, input order, output curLow);
endinterface : psp_burst_if

interface psp_tap_if;
	logic tckRise;
	logic tckFall;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdoOe;
	modport ctl  (output tckRise, output tckFall, output tms, output tdi, input tdo, input tdoOe);
	modport core (input tckRise, input tckFall, input tms, input tdi, output tdo, output tdoOe);
endinterface : psp_tap_if

// *** psp_burst.sv ***
// two-bit burst sequencer, linear or interleaved
`timescale 1ns/1ps
module psp_burst (
	// clock and reset
	input wire logic   clk,
	input wire logic   nrst,
	// control side
	psp_burst_if.core  bus
);
	typedef struct packed {
		psp_pkg::psp_low_t base;
		psp_pkg::psp_low_t cnt;
	} psp_burst_s;

	psp_burst_s stReg;
	psp_burst_s stNext;

	always_comb begin
		stNext = stReg;
		if (bus.step) begin
			if (bus.load) begin
				stNext.base = bus.loadLow;
				stNext.cnt  = psp_pkg::BURST_START;
			end else begin
				// counter wraps after four accesses
				stNext.cnt = psp_pkg::psp_low_t'(stReg.cnt + psp_pkg::BURST_STEP);
			end
		end
	end

	// high order is interleaved, low is linear
	assign bus.curLow = bus.order ? (stReg.base ^ stReg.cnt)
		: psp_pkg::psp_low_t'(stReg.base + stReg.cnt);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stReg <= '0;
		end else begin
			stReg <= stNext;
		end
	end

	a_burst_wrap_step: assert property (@(posedge clk) disable iff (!nrst)
		(bus.step && !bus.load) |=> (stReg.cnt == psp_pkg::psp_low_t'($past(stReg.cnt) + 2'h1)))
		else $error("burst counter did not advance by one");
endmodule : psp_burst

// *** psp_tap.sv ***
// test access port: sixteen-state controller with bypass data path
`timescale 1ns/1ps
module psp_tap (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// qualified test clock edges and serial pins
	psp_tap_if.core  tp
);
	typedef struct packed {
		psp_pkg::psp_tap_e state;
		psp_pkg::psp_ir_t  ir;
		psp_pkg::psp_ir_t  irShift;
		logic              bypass;
		logic              tdo;
		logic              tdoOe;
	} psp_tap_s;

	psp_tap_s stReg;
	psp_tap_s stNext;

	function automatic psp_pkg::psp_tap_e tapStep(psp_pkg::psp_tap_e s, logic m);
		case (s)
			psp_pkg::TAP_RESET:  tapStep = m ? psp_pkg::TAP_RESET  : psp_pkg::TAP_IDLE;
			psp_pkg::TAP_IDLE:   tapStep = m ? psp_pkg::TAP_SEL_DR : psp_pkg::TAP_IDLE;
			psp_pkg::TAP_SEL_DR: tapStep = m ? psp_pkg::TAP_SEL_IR : psp_pkg::TAP_CAP_DR;
			psp_pkg::TAP_CAP_DR: tapStep = m ? psp_pkg::TAP_EX1_DR : psp_pkg::TAP_SH_DR;
			psp_pkg::TAP_SH_DR:  tapStep = m ? psp_pkg::TAP_EX1_DR : psp_pkg::TAP_SH_DR;
			psp_pkg::TAP_EX1_DR: tapStep = m ? psp_pkg::TAP_UPD_DR : psp_pkg::TAP_PA_DR;
			psp_pkg::TAP_PA_DR:  tapStep = m ? psp_pkg::TAP_EX2_DR : psp_pkg::TAP_PA_DR;
			psp_pkg::TAP_EX2_DR: tapStep = m ? psp_pkg::TAP_UPD_DR : psp_pkg::TAP_SH_DR;
			psp_pkg::TAP_UPD_DR: tapStep = m ? psp_pkg::TAP_SEL_DR : psp_pkg::TAP_IDLE;
			psp_pkg::TAP_SEL_IR: tapStep = m ? psp_pkg::TAP_RESET  : psp_pkg::TAP_CAP_IR;
			psp_pkg::TAP_CAP_IR: tapStep = m ? psp_pkg::TAP_EX1_IR : psp_pkg::TAP_SH_IR;
			psp_pkg::TAP_SH_IR:  tapStep = m ? psp_pkg::TAP_EX1_IR : psp_pkg::TAP_SH_IR;
			psp_pkg::TAP_EX1_IR: tapStep = m ? psp_pkg::TAP_UPD_IR : psp_pkg::TAP_PA_IR;
			psp_pkg::TAP_PA_IR:  tapStep = m ? psp_pkg::TAP_EX2_IR : psp_pkg::TAP_PA_IR;
			psp_pkg::TAP_EX2_IR: tapStep = m ? psp_pkg::TAP_UPD_IR : psp_pkg::TAP_SH_IR;
			psp_pkg::TAP_UPD_IR: tapStep = m ? psp_pkg::TAP_SEL_DR : psp_pkg::TAP_IDLE;
			default:             tapStep = psp_pkg::TAP_RESET;
		endcase
	endfunction : tapStep

	always_comb begin
		stNext = stReg;
		if (tp.tckRise) begin
			stNext.state = tapStep(stReg.state, tp.tms);
			case (stReg.state)
				psp_pkg::TAP_RESET:  stNext.ir = psp_pkg::IR_BYPASS;
				psp_pkg::TAP_CAP_IR: stNext.irShift = psp_pkg::IR_CAPTURE;
				psp_pkg::TAP_SH_IR:  stNext.irShift = {tp.tdi, stReg.irShift[psp_pkg::IR_W-1:1]};
				psp_pkg::TAP_UPD_IR: stNext.ir = stReg.irShift;
				psp_pkg::TAP_CAP_DR: stNext.bypass = 1'h0;
				psp_pkg::TAP_SH_DR:  stNext.bypass = tp.tdi;
				default:             stNext.bypass = stReg.bypass;
			endcase
		end
		// output moves only on the falling test clock edge
		if (tp.tckFall) begin
			stNext.tdo   = (stReg.state == psp_pkg::TAP_SH_IR) ? stReg.irShift[0] : stReg.bypass;
			stNext.tdoOe = (stReg.state == psp_pkg::TAP_SH_IR) || (stReg.state == psp_pkg::TAP_SH_DR);
		end
	end

	assign tp.tdo   = stReg.tdo;
	assign tp.tdoOe = stReg.tdoOe;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stReg       <= '0;
			stReg.state <= psp_pkg::TAP_RESET;
			stReg.ir    <= psp_pkg::IR_BYPASS;
		end else begin
			stReg <= stNext;
		end
	end

	a_tdo_falling_only: assert property (@(posedge clk) disable iff (!nrst)
		!tp.tckFall |=> $stable(stReg.tdo) && $stable(stReg.tdoOe))
		else $error("serial output moved without a falling test clock");
	a_tdi_rise_sample: assert property (@(posedge clk) disable iff (!nrst)
		(tp.tckRise && stReg.state == psp_pkg::TAP_SH_DR) |=> (stReg.bypass == $past(tp.tdi)))
		else $error("bypass stage did not take serial input");
	a_tms_reset_hold: assert property (@(posedge clk) disable iff (!nrst)
		(tp.tckRise && tp.tms && stReg.state == psp_pkg::TAP_RESET) |=> stReg.state == psp_pkg::TAP_RESET)
		else $error("controller left reset with mode select high");
	a_tap_idle_walk: assert property (@(posedge clk) disable iff (!nrst)
		(tp.tckRise && !tp.tms && stReg.state == psp_pkg::TAP_SEL_DR) |=> stReg.state == psp_pkg::TAP_CAP_DR)
		else $error("controller missed capture step");
endmodule : psp_tap

// *** psp_port.sv ***
// pipelined burst sram host port: selects, output control, clock qualification, lanes
// ----------------------------------------------------------------
// Summary of operation
// - selected only with both low selects low and high select high, sampled together
// - output enable low drives data and parity pins even while masked
// - output enable high tristates data and parity so they act as inputs
// - pins stay tristated in write data cycle, after deselect exit, and while deselected
// - only clock edges with clock enable low advance the access pipeline
// - clock enable high masks the edge; no capture, pipeline state held
// - clock enable high does not deselect; the cycle simply stretches
// - write data is captured into the storage array on a rising edge
// - read data belongs to the address taken at the previous qualified edge
// - parity lanes act like data lanes, written only with their byte select
// - burst strap high selects interleaved order, low selects linear order
// - an unconnected burst strap defaults high, interleaved
// - test output changes on the falling test clock edge
// - test input is sampled on the rising test clock edge
// - test mode select is sampled on rising test clock and steers the controller
// - each byte select, with write enable, gates its byte and parity bit
// - both burst orders step the two lowest address bits and wrap after four
// - a sampled deselect tristates outputs after the following edge
// ----------------------------------------------------------------
`timescale 1ns/1ps
module psp_port (
	// clock and reset
	input  wire logic                             clk,
	input  wire logic                             nrst,
	// selects and control
	input  wire logic                             chipSelLowAN,
	input  wire logic                             chipSelHigh,
	input  wire logic                             chipSelLowBN,
	input  wire logic                             clockEnableN,
	input  wire logic                             writeEnableN,
	input  wire logic                             advLoadN,
	input  wire logic [psp_pkg::ADDR_W-1:0]       addr,
	input  wire logic [psp_pkg::LANES-1:0]        byteWriteSelN,
	input  wire logic                             outputEnableN,
	// data and parity lanes
	input  wire logic [psp_pkg::DATA_W-1:0]       dataIn,
	output logic      [psp_pkg::DATA_W-1:0]       dataOut,
	output logic      [psp_pkg::DATA_W-1:0]       dataOe,
	input  wire logic [psp_pkg::LANES-1:0]        parityIn,
	output logic      [psp_pkg::LANES-1:0]        parityOut,
	output logic      [psp_pkg::LANES-1:0]        parityOe,
	// burst order strap
	input  wire logic                             burstOrderStrap,
	// serial test port
	input  wire logic                             tck,
	input  wire logic                             tms,
	input  wire logic                             tdi,
	output logic                                  tdo,
	output logic                                  tdoOe
);
	typedef struct packed {
		logic                          oeS1;
		logic                          oeS2;
		logic                          strapS1;
		logic                          strapS2;
		logic [1:0]                    strapAge;
		logic                          burstOrder;
		logic                          tckS1;
		logic                          tckS2;
		logic                          tckS3;
		logic                          tmsS1;
		logic                          tmsS2;
		logic                          tdiS1;
		logic                          tdiS2;
		logic                          s1Valid;
		logic                          s1Write;
		psp_pkg::psp_high_t            s1High;
		logic [psp_pkg::LANES-1:0]     s1LaneN;
		logic                          s2Write;
		psp_pkg::psp_addr_t            s2Addr;
		logic [psp_pkg::LANES-1:0]     s2LaneN;
		logic                          drive;
		logic                          pinOe;
		logic [psp_pkg::DATA_W-1:0]    outData;
		logic [psp_pkg::LANES-1:0]     outParity;
	} psp_port_s;

	psp_port_s stReg;
	psp_port_s stNext;

	psp_burst_if bIf ();
	psp_tap_if   tIf ();

	logic                        qual;
	logic                        sel;
	psp_pkg::psp_addr_t          s1Addr;
	logic [psp_pkg::DATA_W-1:0]  rdData;
	logic [psp_pkg::LANES-1:0]   rdParity;

	// ----------------------------------------------------------------
	// clock qualification and select decode
	// ----------------------------------------------------------------
	assign qual   = !clockEnableN;
	assign sel    = !chipSelLowAN && chipSelHigh && !chipSelLowBN;
	assign s1Addr = {stReg.s1High, bIf.curLow};

	assign bIf.step    = qual;
	assign bIf.load    = !advLoadN;
	assign bIf.loadLow = addr[psp_pkg::LOW_W-1:0];
	assign bIf.order   = stReg.burstOrder;

	psp_burst u_burst (
		.clk  (clk),
		.nrst (nrst),
		.bus  (bIf)
	);

	// ----------------------------------------------------------------
	// storage, one data array and one parity array per byte lane
	// ----------------------------------------------------------------
	for (genvar ln = 0; ln < psp_pkg::LANES; ln++) begin : g_lane
		logic [psp_pkg::BYTE_W-1:0] byteMem [psp_pkg::DEPTH];
		logic                       parMem  [psp_pkg::DEPTH];

		// write lands at the data edge, two qualified edges after the address
		always_ff @(posedge clk) begin
			if (qual && stReg.s2Write && !stReg.s2LaneN[ln]) begin
				byteMem[stReg.s2Addr] <= dataIn[ln*psp_pkg::BYTE_W +: psp_pkg::BYTE_W];
				parMem[stReg.s2Addr]  <= parityIn[ln];
			end
		end

		assign rdData[ln*psp_pkg::BYTE_W +: psp_pkg::BYTE_W] = byteMem[s1Addr];
		assign rdParity[ln] = parMem[s1Addr];
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		stNext = stReg;
		// pins from outside the clock domain, two stages each, three for the test clock
		stNext.oeS1    = outputEnableN;
		stNext.oeS2    = stReg.oeS1;
		stNext.strapS1 = burstOrderStrap;
		stNext.strapS2 = stReg.strapS1;
		stNext.tckS1   = tck;
		stNext.tckS2   = stReg.tckS1;
		stNext.tckS3   = stReg.tckS2;
		stNext.tmsS1   = tms;
		stNext.tmsS2   = stReg.tmsS1;
		stNext.tdiS1   = tdi;
		stNext.tdiS2   = stReg.tdiS1;

		// strap is taken once after the synchroniser settles; later changes ignored
		if (stReg.strapAge != psp_pkg::STRAP_SETTLE) begin
			stNext.strapAge = 2'(stReg.strapAge + 2'h1);
			if (stNext.strapAge == psp_pkg::STRAP_SETTLE) begin
				stNext.burstOrder = stReg.strapS2;
			end
		end

		// a masked edge holds the access pipeline, selection included
		if (qual) begin
			if (!advLoadN) begin
				stNext.s1Valid = sel;
				stNext.s1Write = !writeEnableN;
				stNext.s1High  = addr[psp_pkg::ADDR_W-1:psp_pkg::LOW_W];
				stNext.s1LaneN = byteWriteSelN;
			end else begin
				// burst continues with the latched direction regardless of selects
				stNext.s1LaneN = byteWriteSelN;
			end
			stNext.s2Write = stReg.s1Valid && stReg.s1Write;
			stNext.s2Addr  = s1Addr;
			stNext.s2LaneN = stReg.s1LaneN;
			// only a selected read drives; write data phase and deselect do not
			stNext.drive   = stReg.s1Valid && !stReg.s1Write;
			if (stReg.s1Valid && !stReg.s1Write) begin
				stNext.outData   = rdData;
				stNext.outParity = rdParity;
			end
		end

		// output enable still acts while the clock is masked
		stNext.pinOe = stNext.drive && !stReg.oeS2;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stReg            <= '0;
			stReg.oeS1       <= 1'h1;
			stReg.oeS2       <= 1'h1;
			stReg.burstOrder <= psp_pkg::STRAP_DEFAULT;
		end else begin
			stReg <= stNext;
		end
	end

	// ----------------------------------------------------------------
	// test port
	// ----------------------------------------------------------------
	assign tIf.tckRise = stReg.tckS2 && !stReg.tckS3;
	assign tIf.tckFall = !stReg.tckS2 && stReg.tckS3;
	assign tIf.tms     = stReg.tmsS2;
	assign tIf.tdi     = stReg.tdiS2;

	psp_tap u_tap (
		.clk  (clk),
		.nrst (nrst),
		.tp   (tIf)
	);

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	assign dataOut   = stReg.outData;
	assign parityOut = stReg.outParity;
	assign dataOe    = {psp_pkg::DATA_W{stReg.pinOe}};
	assign parityOe  = {psp_pkg::LANES{stReg.pinOe}};
	assign tdo       = tIf.tdo;
	assign tdoOe     = tIf.tdoOe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_select_needs_all: assert property (@(posedge clk) disable iff (!nrst)
		(qual && !advLoadN && !sel) |=> !stReg.s1Valid)
		else $error("access taken without full select");
	a_oe_low_drives: assert property (@(posedge clk) disable iff (!nrst)
		(qual && stReg.s1Valid && !stReg.s1Write && !stReg.oeS2) |=> dataOe[0] && parityOe[0])
		else $error("selected read with output enable low did not drive");
	a_oe_high_floats: assert property (@(posedge clk) disable iff (!nrst)
		stReg.oeS2 |=> !dataOe[0] && !parityOe[0])
		else $error("pins driven with output enable high");
	a_write_phase_float: assert property (@(posedge clk) disable iff (!nrst)
		(qual && stReg.s1Valid && stReg.s1Write) |=> !dataOe[0] ##1 (!qual || !dataOe[0] || stReg.drive))
		else $error("pins driven during write data phase");
	a_cen_holds_state: assert property (@(posedge clk) disable iff (!nrst)
		clockEnableN |=> $stable(stReg.s1Valid) && $stable(stReg.s1High) && $stable(stReg.outData)
			&& $stable(stReg.drive))
		else $error("state moved on a masked clock edge");
	a_read_pipe_data: assert property (@(posedge clk) disable iff (!nrst)
		(qual && stReg.s1Valid && !stReg.s1Write) |=> (dataOut == $past(rdData))
			&& (parityOut == $past(rdParity)))
		else $error("read data not from the previously taken address");
	a_deselect_pipe: assert property (@(posedge clk) disable iff (!nrst)
		(qual && !advLoadN && !sel) ##1 qual |=> !dataOe[0])
		else $error("outputs still driven after pipelined deselect");
	a_strap_stays: assert property (@(posedge clk) disable iff (!nrst)
		(stReg.strapAge == psp_pkg::STRAP_SETTLE) |=> $stable(stReg.burstOrder))
		else $error("burst order changed after it was taken");
	a_strap_default: assert property (@(posedge clk) disable iff (!nrst)
		(stReg.strapAge == 2'h0) |-> stReg.burstOrder)
		else $error("burst order not interleaved out of reset");
endmodule : psp_port

// *** psp_host.sv ***
// host-side model of the shared data and parity wires and the burst strap pin
`timescale 1ns/1ps
module psp_host (
	// clock
	input  wire logic                        clk,
	// device side of the lanes
	input  wire logic [psp_pkg::DATA_W-1:0]  dataOut,
	input  wire logic [psp_pkg::DATA_W-1:0]  dataOe,
	input  wire logic [psp_pkg::LANES-1:0]   parityOut,
	input  wire logic [psp_pkg::LANES-1:0]   parityOe,
	// host drive of the lanes
	input  wire logic [35:0]                 hostData,
	input  wire logic                        hostDrive,
	// resolved wire levels
	output logic      [psp_pkg::DATA_W-1:0]  dataIn,
	output logic      [psp_pkg::LANES-1:0]   parityIn,
	output logic                             clash,
	// strap pin
	input  wire logic                        strapFloat,
	input  wire logic                        strapLevel,
	output logic                             burstOrderStrap
);
	logic [35:0] lastWire;
	logic [35:0] devOe;
	logic [35:0] wireVal;

	assign devOe = {parityOe, dataOe};
	// undriven bits show the inverse of the last level, so a stale value never passes
	assign wireVal = (devOe & {parityOut, dataOut}) |
		(~devOe & (hostDrive ? hostData : ~lastWire));
	assign {parityIn, dataIn} = wireVal;
	assign clash = hostDrive & (|devOe);
	// a floating strap is pulled high
	assign burstOrderStrap = strapFloat ? 1'b1 : strapLevel;

	initial lastWire = 36'h0;
	always @(posedge clk) begin
		lastWire <= wireVal;
	end
endmodule : psp_host

// *** testbench.sv ***
// self-checking bench for the pipelined sram host port
`timescale 1ns/1ps
module testbench;
	logic        clk, nrst, csLowAN, csHigh, csLowBN, clockEnableN;
	logic        writeEnableN, advLoadN, outputEnableN;
	logic [5:0]  addr;
	logic [3:0]  byteWriteSelN, parityIn, parityOut, parityOe;
	logic [31:0] dataIn, dataOut, dataOe;
	logic [35:0] hostData;
	logic        hostDrive, clash, strapFloat, strapLevel, burstOrderStrap, tdo, tdoOe;
	logic        tck, tms, tdi;
	int          failures, compares, cycles;

	localparam logic [2:0]  SEL   = 3'h2;
	localparam logic [2:0]  DESEL = 3'h0;
	localparam logic [35:0] ALL   = 36'hF_FFFF_FFFF;

	psp_port dut_u (.clk(clk), .nrst(nrst), .chipSelLowAN(csLowAN), .chipSelHigh(csHigh),
		.chipSelLowBN(csLowBN), .clockEnableN(clockEnableN), .writeEnableN(writeEnableN),
		.advLoadN(advLoadN), .addr(addr), .byteWriteSelN(byteWriteSelN),
		.outputEnableN(outputEnableN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
		.parityIn(parityIn), .parityOut(parityOut), .parityOe(parityOe),
		.burstOrderStrap(burstOrderStrap), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdoOe(tdoOe));

	psp_host host_u (.clk(clk), .dataOut(dataOut), .dataOe(dataOe), .parityOut(parityOut),
		.parityOe(parityOe), .hostData(hostData), .hostDrive(hostDrive), .dataIn(dataIn),
		.parityIn(parityIn), .clash(clash), .strapFloat(strapFloat), .strapLevel(strapLevel),
		.burstOrderStrap(burstOrderStrap));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(string nm, logic [35:0] seen, logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic req(logic [2:0] sel, logic we, logic adv, logic [5:0] a, logic [3:0] bw);
		{csLowAN, csHigh, csLowBN} <= sel;
		writeEnableN               <= we;
		advLoadN                   <= adv;
		addr                       <= a;
		byteWriteSelN              <= bw;
	endtask : req

	function automatic logic [35:0] pat(logic [5:0] a);
		return {a[3:0] ^ 4'h9, 32'h5A5A_0000 + 32'(a)};
	endfunction : pat

	task automatic do_reset(logic fl, logic lv);
		nrst       <= 1'b0;
		strapFloat <= fl;
		strapLevel <= lv;
		req(DESEL, 1'b1, 1'b0, 6'h00, 4'hF);
		tick(16);
		nrst <= 1'b1;
		tick(1);
	endtask : do_reset

	// write: select and load edge, deselect edge, then host data sampled at the third edge
	// byte selects travel with the address edge
	task automatic wr(logic [5:0] a, logic [35:0] d, logic [3:0] bw);
		req(SEL, 1'b0, 1'b0, a, bw);
		tick(1);
		req(DESEL, 1'b1, 1'b0, 6'h00, 4'hF);
		tick(1);
		#1;
		chk("drive in write data cycle", {parityOe, dataOe}, 36'h0);
		hostData  <= d;
		hostDrive <= 1'b1;
		#1;
		chk("bus clash", 36'(clash), 36'h0);
		tick(1);
		hostDrive <= 1'b0;
	endtask : wr

	// one test clock phase, held long enough for the pin synchroniser
	task automatic tap_half(logic lvl, logic m, logic d);
		tick(1);
		tms <= m;
		tdi <= d;
		tck <= lvl;
		tick(4);
		#1;
	endtask : tap_half

	task automatic tap_bit(logic m, logic d);
		tap_half(1'b1, m, d);
		tap_half(1'b0, m, d);
	endtask : tap_bit

	task automatic rd(logic [2:0] sel, logic [5:0] a, logic drv, logic [35:0] d);
		req(sel, 1'b1, 1'b0, a, 4'hF);
		tick(1);
		req(DESEL, 1'b1, 1'b0, 6'h00, 4'hF);
		tick(1);
		#1;
		chk("read drive", {parityOe, dataOe}, drv ? ALL : 36'h0);
		if (drv) chk("read data", {parityOut, dataOut}, d);
		tick(1);
		#1;
		chk("drive after deselect", {parityOe, dataOe}, 36'h0);
	endtask : rd

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	logic [35:0] merged;

	task automatic t_lanes;
		merged = (~pat(6'h06) & 36'h5_00FF_00FF) | (pat(6'h06) & ~36'h5_00FF_00FF);
		wr(6'h05, pat(6'h05), 4'h0);
		wr(6'h06, pat(6'h06), 4'h0);
		wr(6'h06, ~pat(6'h06), 4'hA);
		rd(SEL, 6'h05, 1'b1, pat(6'h05));
		rd(SEL, 6'h06, 1'b1, merged);
	endtask : t_lanes

	task automatic t_selects;
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), 6'h05, i == 2, pat(6'h05));
		end
	endtask : t_selects

	task automatic t_oe_high;
		outputEnableN <= 1'b1;
		tick(4);
		rd(SEL, 6'h06, 1'b0, merged);
		outputEnableN <= 1'b0;
		tick(4);
		rd(SEL, 6'h05, 1'b1, pat(6'h05));
	endtask : t_oe_high

	// a masked edge must neither capture the write nor drop the pending read
	task automatic t_stretch;
		req(SEL, 1'b1, 1'b0, 6'h06, 4'hF);
		tick(1);
		clockEnableN <= 1'b1;
		req(SEL, 1'b0, 1'b0, 6'h06, 4'h0);
		tick(3);
		#1;
		chk("held data", {parityOut, dataOut}, pat(6'h05));
		chk("held drive", {parityOe, dataOe}, 36'h0);
		clockEnableN <= 1'b0;
		req(DESEL, 1'b1, 1'b0, 6'h00, 4'hF);
		tick(1);
		#1;
		chk("stretched read data", {parityOut, dataOut}, merged);
		chk("stretched read drive", {parityOe, dataOe}, ALL);
		tick(1);
		rd(SEL, 6'h06, 1'b1, merged);
	endtask : t_stretch

	// walk to shift-dr, push one bit through bypass, then back to reset
	task automatic t_tap;
		for (int k = 0; k < 2; k++) begin
			tap_bit(1'b0, 1'b0);
			tap_bit(1'b1, 1'b0);
			tap_bit(1'b0, 1'b0);
			tap_bit(1'b0, 1'b0);
			chk("shift output enable", 36'(tdoOe), 36'h1);
			chk("bypass capture", 36'(tdo), 36'h0);
			tap_half(1'b1, 1'b0, 1'b1);
			chk("output before falling test clock", 36'(tdo), 36'h0);
			tap_half(1'b0, 1'b0, 1'b1);
			chk("bypass shift", 36'(tdo), 36'h1);
			repeat (6) tap_bit(1'b1, 1'b0);
			chk("output enable after exit", 36'(tdoOe), 36'h0);
		end
	endtask : t_tap

	task automatic t_burst(logic fl, logic lv, logic [5:0] o1, logic [5:0] o2, logic [5:0] o3);
		logic [5:0] seq [4];
		seq = '{6'h05, o1, o2, o3};
		do_reset(fl, lv);
		for (int i = 4; i < 8; i++) begin
			wr(6'(i), pat(6'(i)), 4'h0);
		end
		req(SEL, 1'b1, 1'b0, 6'h05, 4'hF);
		for (int i = 0; i < 5; i++) begin
			tick(1);
			#1;
			if (i > 0) chk("burst beat", {parityOut, dataOut}, pat(seq[i-1]));
			req(i < 3 ? SEL : DESEL, 1'b1, i < 3, 6'h00, 4'hF);
		end
		tick(1);
	endtask : t_burst

	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	initial begin
		failures      = 0;
		compares      = 0;
		cycles        = 0;
		nrst          = 1'b0;
		clockEnableN  = 1'b0;
		outputEnableN = 1'b0;
		hostDrive     = 1'b0;
		hostData      = 36'h0;
		tck           = 1'b0;
		tms           = 1'b1;
		tdi           = 1'b0;
		do_reset(1'b0, 1'b1);
		t_lanes;
		t_selects;
		t_oe_high;
		t_stretch;
		t_tap;
		t_burst(1'b1, 1'b0, 6'h04, 6'h07, 6'h06);
		t_burst(1'b0, 1'b0, 6'h06, 6'h07, 6'h04);
		stop_test;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			stop_test;
		end
	end
endmodule : testbench
